// [hw/scp_device.sv]
// Device end of the serial control port, SPI or I2C slave
`timescale 1ns/100ps
module scp_device
   import scp_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link pins
   scp_link_if.dev link,
   // Mode strap, high selects I2C
   input wire logic i2c_mode,
   // Read data from the core
   input wire logic rd_valid,
   output logic rd_ready,
   input wire logic [BYTE_W-1:0] rd_data,
   // Write data to the core
   output logic wr_valid,
   output logic [BYTE_W-1:0] wr_data,
   // Attention request as driven on the link
   output logic rd_pending
);
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_DATA = 3'b011,
      D_ACK = 3'b010,
      D_SKIP = 3'b110
   } scp_dst_t;

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] flt;
      scp_dst_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] txreg;
      logic rd;
      logic sdo;
      logic sdo_oe;
      logic sda_oe;
      logic attn_oe;
      logic hold;
      logic wr_valid;
      logic [7:0] wr_data;
   } scp_dev_state_t;

   localparam scp_dev_state_t DEV_RST = '{
      s1: DEV_SYNC_RST, s2: DEV_SYNC_RST, s3: DEV_SYNC_RST, flt: DEV_SYNC_RST,
      st: D_IDLE, bitcnt: 4'h0, shreg: 8'h00, txreg: IDLE_BYTE, rd: 1'b0,
      sdo: 1'b1, sdo_oe: 1'b0, sda_oe: 1'b0, attn_oe: 1'b0, hold: 1'b0,
      wr_valid: 1'b0, wr_data: 8'h00};

   scp_dev_state_t r;
   scp_dev_state_t nx;
   logic q_valid;
   logic [BYTE_W-1:0] q_data;
   logic pop;
   logic rise;
   logic fall;
   logic cs_fall;
   logic i2c_start;
   logic i2c_stop;
   logic [7:0] in_byte;
   logic [7:0] load;

   // Read data queue between core and link
   scp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .clock(clock),
      .rstn(rstn),
      .in_valid(rd_valid),
      .in_ready(rd_ready),
      .in_data(rd_data),
      .out_valid(q_valid),
      .out_ready(pop),
      .out_data(q_data)
   );

   // Next state of the whole port
   always_comb begin
      nx = r;
      pop = 1'b0;
      nx.wr_valid = 1'b0;
      // Three-stage synchronisers, a change counts when stages two and three agree
      nx.s1 = {link.serial_ctrl_data_io, link.serial_ctrl_data_in,
               link.chip_sel_n, link.serial_ctrl_clock};
      nx.s2 = r.s1;
      nx.s3 = r.s2;
      nx.flt = (r.s2 & r.s3) | (r.flt & (r.s2 ^ r.s3));
      rise = nx.flt[LN_CLK] & ~r.flt[LN_CLK];
      fall = ~nx.flt[LN_CLK] & r.flt[LN_CLK];
      cs_fall = ~nx.flt[LN_CS] & r.flt[LN_CS];
      i2c_start = r.flt[LN_CLK] & nx.flt[LN_CLK] & r.flt[LN_SDA] & ~nx.flt[LN_SDA];
      i2c_stop = r.flt[LN_CLK] & nx.flt[LN_CLK] & ~r.flt[LN_SDA] & nx.flt[LN_SDA];
      in_byte = {r.shreg[6:0], i2c_mode ? nx.flt[LN_SDA] : nx.flt[LN_DIN]};
      load = q_valid ? q_data : IDLE_BYTE;
      // Attention follows queued data; during a read byte it can set but not clear until the empty-queue release
      if (rise) begin
         nx.hold = 1'b0;
      end
      if (r.st == D_DATA && r.rd) begin
         nx.attn_oe = r.attn_oe | (q_valid & ~nx.hold);
      end else begin
         nx.attn_oe = ~nx.hold & q_valid;
      end
      if (!i2c_mode) begin
         // SPI slave
         if (nx.flt[LN_CS]) begin
            nx.st = D_IDLE;
            nx.sdo_oe = 1'b0;
            nx.rd = 1'b0;
         end else if (cs_fall) begin
            nx.st = D_ADDR;
            nx.bitcnt = 4'h0;
         end else if (rise && (r.st == D_ADDR || r.st == D_DATA)) begin
            nx.shreg = in_byte;
            nx.bitcnt = r.bitcnt + 4'h1;
            if (r.st == D_DATA && r.rd && r.bitcnt == 4'h6 && !q_valid) begin
               nx.attn_oe = 1'b0;
               nx.hold = 1'b1;
            end
            if (r.bitcnt == 4'h7) begin
               nx.bitcnt = 4'h0;
               if (r.st == D_ADDR) begin
                  if (in_byte[7:1] == DEV_ADDR) begin
                     nx.st = D_DATA;
                     nx.rd = in_byte[0];
                     if (in_byte[0]) begin
                        nx.txreg = load;
                        pop = q_valid;
                        nx.sdo_oe = 1'b1;
                     end
                  end else begin
                     nx.st = D_SKIP;
                  end
               end else if (r.rd) begin
                  nx.txreg = load;
                  pop = q_valid;
               end else begin
                  nx.wr_valid = 1'b1;
                  nx.wr_data = in_byte;
               end
            end
         end else if (fall && r.st == D_DATA && r.rd) begin
            nx.sdo = r.txreg[7];
            nx.txreg = {r.txreg[6:0], 1'b1};
         end
      end else begin
         // I2C slave
         nx.sdo_oe = 1'b0;
         if (i2c_start) begin
            nx.st = D_ADDR;
            nx.bitcnt = 4'h0;
            nx.sda_oe = 1'b0;
            nx.rd = 1'b0;
         end else if (i2c_stop) begin
            nx.st = D_IDLE;
            nx.sda_oe = 1'b0;
            nx.rd = 1'b0;
         end else if (rise && (r.st == D_ADDR || r.st == D_DATA || r.st == D_ACK)) begin
            nx.shreg = in_byte;
            if (r.st != D_ACK) begin
               nx.bitcnt = r.bitcnt + 4'h1;
            end
            if (r.st == D_DATA && r.rd && r.bitcnt == 4'h7 && !q_valid) begin
               nx.attn_oe = 1'b0;
               nx.hold = 1'b1;
            end
         end else if (fall) begin
            case (r.st)
               D_ADDR: begin
                  if (r.bitcnt == 4'h8) begin
                     if (r.shreg[7:1] == DEV_ADDR) begin
                        nx.sda_oe = 1'b1;
                        nx.rd = r.shreg[0];
                        nx.st = D_ACK;
                     end else begin
                        nx.st = D_SKIP;
                     end
                  end
               end
               D_DATA: begin
                  if (r.bitcnt == 4'h8) begin
                     nx.bitcnt = 4'h0;
                     nx.st = D_ACK;
                     nx.sda_oe = ~r.rd;
                     if (!r.rd) begin
                        nx.wr_valid = 1'b1;
                        nx.wr_data = r.shreg;
                     end
                  end else if (r.rd) begin
                     nx.sda_oe = ~r.txreg[7];
                     nx.txreg = {r.txreg[6:0], 1'b1};
                  end
               end
               D_ACK: begin
                  nx.bitcnt = 4'h0;
                  if (r.rd && r.shreg[0]) begin
                     nx.sda_oe = 1'b0;
                     nx.st = D_SKIP;
                  end else begin
                     nx.st = D_DATA;
                     nx.sda_oe = r.rd & ~load[7];
                     if (r.rd) begin
                        nx.txreg = {load[6:0], 1'b1};
                        pop = q_valid;
                     end
                  end
               end
               default: begin
                  nx.sda_oe = 1'b0;
               end
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= DEV_RST;
      end else begin
         r <= nx;
      end
   end

   // Pin drive, attention only ever pulls low
   assign link.dev_data_out = r.sdo;
   assign link.dev_data_out_oe = r.sdo_oe;
   assign link.dev_data_io_out = 1'b0;
   assign link.dev_data_io_oe = r.sda_oe;
   assign link.dev_attn_out = 1'b0;
   assign link.dev_attn_oe = r.attn_oe;
   assign wr_valid = r.wr_valid;
   assign wr_data = r.wr_data;
   assign rd_pending = r.attn_oe;
endmodule

// [include/scp_pkg.sv]
// Shared constants for the serial control port ends
package scp_pkg;
   // Clock and link timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int SPI_FMAX_KHZ = 2000;
   localparam int I2C_FMAX_KHZ = 400;
   localparam int I2C_HDST_NS = 4000;
   localparam int I2C_SUSP_NS = 4700;
   localparam int I2C_BUF_NS = 4700;
   localparam logic [10:0] SPI_HALF_CYC =
      11'((1000000 / (2 * SPI_FMAX_KHZ) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] I2C_HALF_CYC =
      11'((1000000 / (2 * I2C_FMAX_KHZ) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] I2C_HDST_CYC = 11'((I2C_HDST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] I2C_SUSP_CYC = 11'((I2C_SUSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] I2C_BUF_CYC = 11'((I2C_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Addressing and data
   localparam logic [6:0] DEV_ADDR = 7'h1a;
   localparam logic [7:0] IDLE_BYTE = 8'hff;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 4;
   // Synchroniser lanes and their reset level
   localparam logic [3:0] DEV_SYNC_RST = 4'hf;
   localparam logic [2:0] HOST_SYNC_RST = 3'h7;
   localparam int LN_CLK = 0;
   localparam int LN_CS = 1;
   localparam int LN_DIN = 2;
   localparam int LN_SDA = 3;
   localparam int HL_DOUT = 0;
   localparam int HL_SDA = 1;
   localparam int HL_ATTN = 2;
endpackage

// [include/scp_link_if.sv]
// Pin bundle joining host and device ends of the control port
`timescale 1ns/100ps
interface scp_link_if;
   logic serial_ctrl_clock;
   logic chip_sel_n;
   logic serial_ctrl_data_in;
   logic dev_data_out;
   logic dev_data_out_oe;
   logic serial_ctrl_data_out;
   logic dev_data_io_out;
   logic dev_data_io_oe;
   logic host_data_io_out;
   logic host_data_io_oe;
   logic serial_ctrl_data_io;
   logic dev_attn_out;
   logic dev_attn_oe;
   logic host_attention_req;
   // Wire levels with pull-ups on released lines
   assign serial_ctrl_data_out = dev_data_out_oe ? dev_data_out : 1'b1;
   assign serial_ctrl_data_io = ~((dev_data_io_oe & ~dev_data_io_out) |
                                  (host_data_io_oe & ~host_data_io_out));
   assign host_attention_req = ~(dev_attn_oe & ~dev_attn_out);
   modport dev (input serial_ctrl_clock, chip_sel_n, serial_ctrl_data_in,
                serial_ctrl_data_io, output dev_data_out, dev_data_out_oe,
                dev_data_io_out, dev_data_io_oe, dev_attn_out, dev_attn_oe);
   modport host (output serial_ctrl_clock, chip_sel_n, serial_ctrl_data_in,
                 host_data_io_out, host_data_io_oe, input serial_ctrl_data_out,
                 serial_ctrl_data_io, host_attention_req);
endinterface

// [hw/scp_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module scp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } scp_fifo_state_t;
   scp_fifo_state_t r;
   scp_fifo_state_t nx;

   // Full when pointers differ only in the wrap bit
   assign in_ready = ~((r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]));
   assign out_valid = (r.wp != r.rp);
   assign out_data = r.mem[r.rp[AW-1:0]];

   // Pointer and storage update
   always_comb begin
      nx = r;
      if (in_valid && in_ready) begin
         nx.mem[r.wp[AW-1:0]] = in_data;
         nx.wp = r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         nx.rp = r.rp + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= nx;
      end
   end
endmodule

// [hw/scp_host.sv]
// Host end of the serial control port, SPI or I2C master
`timescale 1ns/100ps
module scp_host
   import scp_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link pins
   scp_link_if.host link,
   // Mode select, high selects I2C
   input wire logic i2c_mode,
   // Byte requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_read,
   input wire logic req_last,
   input wire logic [BYTE_W-1:0] req_data,
   // Read answers and status
   output logic rsp_valid,
   output logic [BYTE_W-1:0] rsp_data,
   output logic attn_seen,
   output logic busy
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0000,
      H_START = 4'b0001,
      H_BLO = 4'b0011,
      H_BHI = 4'b0010,
      H_ALO = 4'b0110,
      H_AHI = 4'b0111,
      H_WAIT = 4'b0101,
      H_STOP = 4'b0100,
      H_GAP = 4'b1100
   } scp_hst_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] flt;
      scp_hst_t st;
      logic [10:0] cnt;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic [7:0] dat;
      logic rd;
      logic last;
      logic hdr;
      logic stop_ph;
      logic sclk;
      logic cs_n;
      logic mosi;
      logic sda_oe;
      logic rsp_valid;
      logic [7:0] rsp_data;
   } scp_host_state_t;

   localparam scp_host_state_t HOST_RST = '{
      s1: HOST_SYNC_RST, s2: HOST_SYNC_RST, s3: HOST_SYNC_RST, flt: HOST_SYNC_RST,
      st: H_IDLE, cnt: 11'h0, bitn: 3'h0, sh: 8'h00, dat: 8'h00, rd: 1'b0,
      last: 1'b0, hdr: 1'b0, stop_ph: 1'b0, sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0,
      sda_oe: 1'b0, rsp_valid: 1'b0, rsp_data: 8'h00};

   scp_host_state_t r;
   scp_host_state_t nx;
   logic tick;
   logic done;
   logic smp;
   logic [10:0] half;

   assign req_ready = (r.st == H_IDLE) || (r.st == H_WAIT);

   // Divider, bit sequencer and synchronisers
   always_comb begin
      nx = r;
      done = 1'b0;
      nx.rsp_valid = 1'b0;
      nx.s1 = {link.host_attention_req, link.serial_ctrl_data_io, link.serial_ctrl_data_out};
      nx.s2 = r.s1;
      nx.s3 = r.s2;
      nx.flt = (r.s2 & r.s3) | (r.flt & (r.s2 ^ r.s3));
      half = i2c_mode ? I2C_HALF_CYC : SPI_HALF_CYC;
      tick = (r.cnt == 11'h0);
      // Sample the line late in the high phase, long after it settled
      smp = i2c_mode ? r.flt[HL_SDA] : r.flt[HL_DOUT];
      if (!tick) begin
         nx.cnt = r.cnt - 11'h1;
      end
      case (r.st)
         H_IDLE: begin
            nx.sclk = i2c_mode;
            if (req_valid) begin
               nx.rd = req_read;
               nx.last = req_last;
               nx.dat = req_data;
               nx.hdr = 1'b1;
               nx.sh = {DEV_ADDR, req_read};
               nx.st = H_START;
               nx.cnt = i2c_mode ? I2C_HDST_CYC : half;
               nx.sda_oe = i2c_mode;
               nx.cs_n = i2c_mode;
            end
         end
         H_START: begin
            if (tick) begin
               nx.st = H_BLO;
               nx.sclk = 1'b0;
               nx.bitn = 3'h0;
               nx.cnt = half;
               nx.mosi = r.sh[7];
               nx.sda_oe = i2c_mode & ~r.sh[7];
            end
         end
         H_BLO: begin
            if (tick) begin
               nx.sclk = 1'b1;
               nx.st = H_BHI;
               nx.cnt = half;
            end
         end
         H_BHI: begin
            if (tick) begin
               nx.sclk = 1'b0;
               nx.cnt = half;
               nx.sh = {r.sh[6:0], smp};
               nx.bitn = r.bitn + 3'h1;
               if (r.bitn != 3'h7) begin
                  nx.st = H_BLO;
                  nx.mosi = r.sh[6];
                  nx.sda_oe = i2c_mode & (r.hdr | ~r.rd) & ~r.sh[6];
               end else if (i2c_mode) begin
                  nx.st = H_ALO;
                  nx.sda_oe = ~r.hdr & r.rd & ~r.last;
               end else begin
                  done = 1'b1;
               end
            end
         end
         H_ALO: begin
            if (tick) begin
               nx.sclk = 1'b1;
               nx.st = H_AHI;
               nx.cnt = half;
            end
         end
         H_AHI: begin
            if (tick) begin
               nx.sclk = 1'b0;
               nx.sda_oe = 1'b0;
               nx.cnt = half;
               done = 1'b1;
            end
         end
         H_WAIT: begin
            if (req_valid) begin
               nx.last = req_last;
               nx.sh = r.rd ? IDLE_BYTE : req_data;
               nx.st = H_BLO;
               nx.cnt = half;
               nx.bitn = 3'h0;
               nx.mosi = req_data[7];
               nx.sda_oe = i2c_mode & ~r.rd & ~req_data[7];
            end
         end
         H_STOP: begin
            if (tick) begin
               if (i2c_mode && !r.stop_ph) begin
                  nx.sclk = 1'b1;
                  nx.stop_ph = 1'b1;
                  nx.cnt = I2C_SUSP_CYC;
               end else begin
                  nx.sda_oe = 1'b0;
                  nx.cs_n = 1'b1;
                  nx.st = H_GAP;
                  nx.cnt = i2c_mode ? I2C_BUF_CYC : half;
               end
            end
         end
         H_GAP: begin
            if (tick) begin
               nx.st = H_IDLE;
            end
         end
         default: begin
            nx.st = H_IDLE;
         end
      endcase
      // End of a byte: follow the header with data, else wait for the next byte or close
      if (done) begin
         nx.bitn = 3'h0;
         if (r.hdr) begin
            nx.hdr = 1'b0;
            nx.sh = r.rd ? IDLE_BYTE : r.dat;
            nx.st = H_BLO;
            nx.mosi = r.dat[7];
            nx.sda_oe = i2c_mode & ~r.rd & ~r.dat[7];
         end else begin
            nx.rsp_valid = r.rd;
            nx.rsp_data = nx.sh;
            nx.st = r.last ? H_STOP : H_WAIT;
            nx.stop_ph = 1'b0;
            nx.sda_oe = i2c_mode & r.last;
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= HOST_RST;
      end else begin
         r <= nx;
      end
   end

   // Pin drive and status
   assign link.serial_ctrl_clock = r.sclk;
   assign link.chip_sel_n = r.cs_n;
   assign link.serial_ctrl_data_in = r.mosi;
   assign link.host_data_io_out = 1'b0;
   assign link.host_data_io_oe = r.sda_oe;
   assign rsp_valid = r.rsp_valid;
   assign rsp_data = r.rsp_data;
   assign attn_seen = ~r.flt[HL_ATTN];
   assign busy = (r.st != H_IDLE);
endmodule

// [verif/scp_link_sva.sv]
// Link pin checks between the host and device ends
`timescale 1ns/100ps
module scp_link_sva
   import scp_pkg::*;
(
   // Clock, reset and mode
   input wire logic clock,
   input wire logic rstn,
   input wire logic i2c_mode,
   // Link pins
   input wire logic serial_ctrl_clock,
   input wire logic chip_sel_n,
   input wire logic dev_data_out_oe,
   input wire logic serial_ctrl_data_out,
   input wire logic dev_data_io_out,
   input wire logic dev_data_io_oe,
   input wire logic dev_attn_out,
   input wire logic host_attention_req
);
   logic clk_q_reg;
   logic [10:0] half_cnt_reg;
   logic tgl;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Cycles since the link clock last toggled, saturating
   assign tgl = serial_ctrl_clock != clk_q_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         clk_q_reg <= 1'b0;
         half_cnt_reg <= 11'h7ff;
      end else begin
         clk_q_reg <= serial_ctrl_clock;
         half_cnt_reg <= tgl ? 11'h0 : half_cnt_reg + {10'h0, half_cnt_reg != 11'h7ff};
      end
   end
   clk_rate_a: assert property (tgl |-> half_cnt_reg >=
      (i2c_mode ? I2C_HALF_CYC : SPI_HALF_CYC) - 11'h1) else $error("link clock too fast");
   cs_lead_a: assert property ($fell(chip_sel_n) |-> !serial_ctrl_clock [*8])
      else $error("clock rose too soon after select");
   cs_trail_a: assert property ($rose(chip_sel_n) |-> !serial_ctrl_clock
      && !$past(serial_ctrl_clock)) else $error("select rose with clock high");
   clk_framed_a: assert property (!i2c_mode && $rose(serial_ctrl_clock) |-> !chip_sel_n)
      else $error("clock edge outside frame");
   out_release_a: assert property (chip_sel_n [*8] |-> !dev_data_out_oe)
      else $error("data out driven while deselected");
   out_stable_a: assert property (!i2c_mode && serial_ctrl_clock && $past(serial_ctrl_clock)
      && $past(dev_data_out_oe, 2) |-> $stable(serial_ctrl_data_out))
      else $error("data out moved while clock high");
   sda_stable_a: assert property (i2c_mode && serial_ctrl_clock && $past(serial_ctrl_clock)
      |-> $stable(dev_data_io_oe)) else $error("data line moved while clock high");
   attn_release_a: assert property ($rose(host_attention_req) |-> serial_ctrl_clock
      && (i2c_mode || !chip_sel_n)) else $error("attention released off the clock edge");
   attn_hold_a: assert property ($rose(host_attention_req) |=> host_attention_req [*8])
      else $error("attention not held high");
   od_pins_a: assert property (!dev_attn_out && !dev_data_io_out)
      else $error("open drain pin driven high");
   // Main traffic seen
   cover property ($rose(dev_data_out_oe));
   cover property ($rose(dev_data_io_oe));
   cover property ($rose(host_attention_req));
endmodule

// [verif/testbench.sv]
// Testbench joining host and device ends over the link
`timescale 1ns/100ps
module testbench import scp_pkg::*;;
   logic clock, rstn, i2c_mode, rd_valid, rd_ready, wr_valid, rd_pending;
   logic req_valid, req_ready, req_read, req_last, rsp_valid, attn_seen, busy;
   logic [7:0] rd_data, wr_data, req_data, rsp_data, sh, hdr;
   logic [31:0] seed;
   logic sda_q;
   int failures, n_compared, cyc, nbit;
   logic [7:0] rd_q[$], wr_q[$], rsp_q[$];
   scp_link_if link();
   scp_device scp_device_i (.clock(clock), .rstn(rstn), .link(link), .i2c_mode(i2c_mode),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_data(wr_data), .rd_pending(rd_pending));
   scp_host scp_host_i (.clock(clock), .rstn(rstn), .link(link), .i2c_mode(i2c_mode),
      .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
      .req_last(req_last), .req_data(req_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .attn_seen(attn_seen), .busy(busy));
   scp_link_sva scp_link_sva_i (.clock(clock), .rstn(rstn), .i2c_mode(i2c_mode),
      .serial_ctrl_clock(link.serial_ctrl_clock), .chip_sel_n(link.chip_sel_n),
      .dev_data_out_oe(link.dev_data_out_oe),
      .serial_ctrl_data_out(link.serial_ctrl_data_out),
      .dev_data_io_out(link.dev_data_io_out), .dev_data_io_oe(link.dev_data_io_oe),
      .dev_attn_out(link.dev_attn_out), .host_attention_req(link.host_attention_req));
   // Free running 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         conclude();
      end
   end
   // Core-side results against the model queues
   always @(negedge clock) begin
      if (wr_valid === 1'b1) check(wr_data, wr_q.size() ? wr_q.pop_front() : 8'hxx);
      if (rsp_valid === 1'b1) check(rsp_data, rsp_q.size() ? rsp_q.pop_front() : 8'hxx);
   end
   // First byte on the wire after select or start
   always @(negedge link.chip_sel_n) nbit = 0;
   // Start: data line fell since the last sample while the link clock is high
   always @(negedge clock) begin
      if (sda_q === 1'b1 && link.serial_ctrl_data_io === 1'b0 &&
          link.serial_ctrl_clock === 1'b1) nbit = 0;
      sda_q = link.serial_ctrl_data_io;
   end
   always @(posedge link.serial_ctrl_clock) begin
      sh = {sh[6:0], i2c_mode ? link.serial_ctrl_data_io : link.serial_ctrl_data_in};
      nbit++;
      if (nbit == 8) check(sh, hdr);
   end
   task automatic do_reset(input logic mode);
      @(negedge clock);
      rstn = 1'b0;
      i2c_mode = mode;
      repeat (5) @(negedge clock);
      rstn = 1'b1;
   endtask
   // One host transaction of n bytes, expectations queued first
   task automatic xfer(input logic rd, input int n);
      int k;
      int w;
      hdr = {DEV_ADDR, rd};
      for (k = 0; k < n; k++) begin
         seed = xs(seed);
         if (rd) rsp_q.push_back(rd_q.size() ? rd_q.pop_front() : IDLE_BYTE);
         else wr_q.push_back(seed[7:0]);
         @(negedge clock);
         req_valid = 1'b1;
         req_read = rd;
         req_last = k == n - 1;
         req_data = seed[7:0];
         w = 0;
         while (req_ready !== 1'b1 && w < 16000) begin
            @(negedge clock);
            w++;
         end
         if (w == 16000) failures++;
         @(negedge clock);
         req_valid = 1'b0;
      end
      w = 0;
      while (busy !== 1'b0 && w < 16000) begin
         @(negedge clock);
         w++;
      end
      if (w == 16000) failures++;
   endtask
   // Push read bytes until the buffer refuses or n are offered
   task automatic fill(input int n);
      int k;
      k = 0;
      do begin
         @(negedge clock);
         seed = xs(seed);
         rd_valid = 1'b1;
         rd_data = seed[7:0];
         if (rd_ready === 1'b1) rd_q.push_back(rd_data);
         k++;
      end while (rd_ready === 1'b1 && k < n);
      @(negedge clock);
      rd_valid = 1'b0;
   endtask
   // Main sequence
   initial begin
      rstn = 1'b0;
      i2c_mode = 1'b0;
      rd_valid = 1'b0;
      rd_data = 8'h0;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_last = 1'b0;
      req_data = 8'h0;
      seed = 32'h3545;
      nbit = 100;
      do_reset(1'b0);
      xfer(1'b0, 3);
      $display("spi write test done");
      fill(6);
      check(8'(rd_q.size()), 8'(FIFO_DEPTH));
      repeat (8) @(negedge clock);
      check({7'h0, link.host_attention_req}, 8'h0);
      check({7'h0, attn_seen}, 8'h1);
      xfer(1'b1, 5);
      check({7'h0, link.host_attention_req}, 8'h1);
      check({7'h0, attn_seen}, 8'h0);
      $display("spi read test done");
      fill(1);
      repeat (40) @(negedge clock);
      check({7'h0, link.host_attention_req}, 8'h0);
      check({7'h0, rd_pending}, 8'h1);
      xfer(1'b1, 2);
      check({7'h0, link.host_attention_req}, 8'h1);
      $display("attention hold test done");
      do_reset(1'b1);
      xfer(1'b0, 2);
      fill(2);
      xfer(1'b1, 2);
      check({7'h0, link.host_attention_req}, 8'h1);
      $display("i2c test done");
      check(8'(wr_q.size() + rsp_q.size()), 8'h0);
      conclude();
   end
endmodule
